//--- snip_params.svh
// constants for the stream-over-network transmit settings bank
`ifndef SNIP_PARAMS_SVH
`define SNIP_PARAMS_SVH
// category codes
`define SNIP_CAT_TX 8'h82
`define SNIP_CAT_IN 8'h83
`define SNIP_CAT_OUT 8'h84
// transmit items
`define SNIP_TX_CHANNEL_ENABLE 8'h01
`define SNIP_TX_FEC_GENERATE 8'h03
`define SNIP_TX_FEC_COLUMN_COUNT 8'h04
`define SNIP_TX_FEC_ROW_COUNT 8'h05
`define SNIP_TX_DESTINATION_IP 8'h06
`define SNIP_TX_ADDRESS_RESOLUTION_STATE 8'h07
`define SNIP_TX_DESTINATION_PORT 8'h08
`define SNIP_TX_PACKETS_PER_DATAGRAM 8'h09
`define SNIP_TX_ENCAPSULATION 8'h0a
`define SNIP_TX_CHANNEL_NUMBER 8'h0b
`define SNIP_TX_SOURCE_KIND 8'h0c
`define SNIP_TX_HOP_LIMIT 8'h0d
// asi input items
`define SNIP_IN_PACKET_LENGTH_SELECT 8'h01
`define SNIP_IN_PORT_NUMBER 8'h02
`define SNIP_IN_LINK_STATE 8'h03
`define SNIP_IN_STREAM_RATE 8'h04
`define SNIP_IN_BYTE_COUNTER 8'h05
`define SNIP_IN_CODE_ERROR_COUNTER 8'h06
`define SNIP_IN_SOURCE_SELECT 8'h07
// asi output items
`define SNIP_OUT_PACKET_LENGTH_SELECT 8'h01
`define SNIP_OUT_PORT_NUMBER 8'h02
`define SNIP_OUT_STREAM_RATE 8'h03
// ranges and fixed values
`define SNIP_FEC_COL_MIN 16'h0001
`define SNIP_FEC_COL_MAX 16'h0014
`define SNIP_FEC_ROW_MIN 16'h0004
`define SNIP_FEC_ROW_MAX 16'h0014
`define SNIP_FEC_AREA_MAX 32'h0000_0064
`define SNIP_PPD_MIN 8'h01
`define SNIP_PPD_MAX 8'h07
`define SNIP_LEN_SEL_MAX 8'h02
`define SNIP_SRC_SEL_MAX 8'h02
`define SNIP_BOOL_MAX 8'h01
`define SNIP_CHANNEL_ONE 32'h0000_0001
`define SNIP_SOURCE_ASI 8'h01
`define SNIP_PORT_ONE 8'h01
`define SNIP_PKT_LEN_188 8'hbc
`define SNIP_PKT_LEN_204 8'hcc
// reset values
`define SNIP_RST_ENABLE 8'h00
`define SNIP_RST_FEC_GEN 8'h00
`define SNIP_RST_FEC_COL 16'h0001
`define SNIP_RST_FEC_ROW 16'h0004
`define SNIP_RST_DEST_IP 32'h0000_0000
`define SNIP_RST_DEST_PORT 16'h0000
`define SNIP_RST_PPD 8'h07
`define SNIP_RST_ENCAP 8'h00
`define SNIP_RST_HOP 8'h40
`define SNIP_RST_LEN_SEL 8'h00
`define SNIP_RST_SRC_SEL 8'h00
`endif

//--- snip_pkg.sv
// types for the stream-over-network transmit settings bank
package snip_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] category;
    logic [7:0] item;
    logic [15:0] index;
    logic [63:0] data;
  } snip_cmd_t;
  typedef struct packed {
    logic valid;
    logic ok;
    logic [63:0] data;
  } snip_rsp_t;
  typedef struct packed {
    logic enable;
    logic fec_generate;
    logic [4:0] tx_fec_column_count;
    logic [4:0] tx_fec_row_count;
    logic [31:0] destination_ip;
    logic [15:0] destination_port;
    logic [2:0] packets_per_datagram;
    logic rtp;
    logic [7:0] hop_limit;
    logic [1:0] in_length_select;
    logic [1:0] source_select;
    logic [1:0] out_length_select;
  } snip_cfg_t;
  typedef struct packed {
    logic [7:0] tx_enable;
    logic [7:0] fec_gen;
    logic [15:0] fec_col;
    logic [15:0] fec_row;
    logic [31:0] dest_ip;
    logic [15:0] dest_port;
    logic [7:0] ppd;
    logic [7:0] encap;
    logic [7:0] hop;
    logic [7:0] in_len;
    logic [7:0] src_sel;
    logic [7:0] out_len;
    logic [7:0] resolve;
    logic [7:0] link;
    logic [31:0] in_rate;
    logic [31:0] out_rate;
    logic [63:0] byte_cnt;
    logic [63:0] viol_cnt;
    snip_rsp_t rsp;
    snip_cfg_t cfg;
    logic [7:0] tx_len;
    logic [7:0] out_bytes;
  } snip_state_t;
endpackage

//--- snip_bank.sv
// settings and status bank for the asi-to-network transmit path
`timescale 1ns/10ps
`include "snip_params.svh"

// Operation
// - transmit items reachable only in asi-to-ip mode
// - fec generation follows the fec item
// - tx_fec_column_count writable, one to twenty
// - tx_fec_row_count writable, four to twenty
// - columns times rows at most one hundred
// - resolution item: 0 resolved, 1 failed
// - destination port full sixteen-bit range
// - one to seven packets per datagram
// - encapsulation 0 plain udp, 1 rtp
// - channel index item always reads one
// - input type item always reads one
// - every packet stamped with configured ttl
// - asi input items only in asi-to-ip mode
// - input length: 188, 204, or incoming
// - input status 0 ok to 3 low rate
// - input rate in bps, 32 bits
// - 64-bit received byte counter
// - 64-bit code violation counter
// - source select: auto default, parallel, asi
// - asi output items only in ip-to-asi mode
// - output length: 188, 204, or received
module snip_bank (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // mode strap level: 1 = asi-to-ip, 0 = ip-to-asi
  input wire logic asi_to_ip_mode,
  // command port from the protocol handler
  input wire snip_pkg::snip_cmd_t cmd,
  output snip_pkg::snip_rsp_t rsp,
  // status from the datapath
  input wire logic resolve_failed,
  input wire logic [1:0] link_state,
  input wire logic [31:0] in_rate_bps,
  input wire logic [31:0] out_rate_bps,
  input wire logic byte_received,
  input wire logic code_violation,
  // settings to the datapath
  output snip_pkg::snip_cfg_t cfg,
  output logic [7:0] tx_packet_length,
  output logic [7:0] out_packet_bytes
);

  //////////////////////////////////////////////////////////////////////////////
  snip_pkg::snip_state_t s_q;
  snip_pkg::snip_state_t s_d;
  logic cat_tx;
  logic cat_in;
  logic cat_out;
  logic wr;
  logic rd_ok;
  logic wr_ok;
  logic [63:0] rd_data;
  logic [31:0] area;

  // category gating by conversion mode; index is carried but only one channel exists
  assign cat_tx = cmd.category == `SNIP_CAT_TX && asi_to_ip_mode;
  assign cat_in = cmd.category == `SNIP_CAT_IN && asi_to_ip_mode;
  assign cat_out = cmd.category == `SNIP_CAT_OUT && !asi_to_ip_mode;
  assign wr = cmd.valid && cmd.write;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 64'h0;
    if (cat_tx) begin
      unique case (cmd.item)
        `SNIP_TX_CHANNEL_ENABLE: rd_data = {56'h0, s_q.tx_enable};
        `SNIP_TX_FEC_GENERATE: rd_data = {56'h0, s_q.fec_gen};
        `SNIP_TX_FEC_COLUMN_COUNT: rd_data = {48'h0, s_q.fec_col};
        `SNIP_TX_FEC_ROW_COUNT: rd_data = {48'h0, s_q.fec_row};
        `SNIP_TX_DESTINATION_IP: rd_data = {32'h0, s_q.dest_ip};
        `SNIP_TX_ADDRESS_RESOLUTION_STATE: rd_data = {56'h0, s_q.resolve};
        `SNIP_TX_DESTINATION_PORT: rd_data = {48'h0, s_q.dest_port};
        `SNIP_TX_PACKETS_PER_DATAGRAM: rd_data = {56'h0, s_q.ppd};
        `SNIP_TX_ENCAPSULATION: rd_data = {56'h0, s_q.encap};
        `SNIP_TX_CHANNEL_NUMBER: rd_data = {32'h0, `SNIP_CHANNEL_ONE};
        `SNIP_TX_SOURCE_KIND: rd_data = {56'h0, `SNIP_SOURCE_ASI};
        `SNIP_TX_HOP_LIMIT: rd_data = {56'h0, s_q.hop};
        default: rd_ok = 1'b0;
      endcase
    end else if (cat_in) begin
      unique case (cmd.item)
        `SNIP_IN_PACKET_LENGTH_SELECT: rd_data = {56'h0, s_q.in_len};
        `SNIP_IN_PORT_NUMBER: rd_data = {56'h0, `SNIP_PORT_ONE};
        `SNIP_IN_LINK_STATE: rd_data = {56'h0, s_q.link};
        `SNIP_IN_STREAM_RATE: rd_data = {32'h0, s_q.in_rate};
        `SNIP_IN_BYTE_COUNTER: rd_data = s_q.byte_cnt;
        `SNIP_IN_CODE_ERROR_COUNTER: rd_data = s_q.viol_cnt;
        `SNIP_IN_SOURCE_SELECT: rd_data = {56'h0, s_q.src_sel};
        default: rd_ok = 1'b0;
      endcase
    end else if (cat_out) begin
      unique case (cmd.item)
        `SNIP_OUT_PACKET_LENGTH_SELECT: rd_data = {56'h0, s_q.out_len};
        `SNIP_OUT_PORT_NUMBER: rd_data = {56'h0, `SNIP_PORT_ONE};
        `SNIP_OUT_STREAM_RATE: rd_data = {32'h0, s_q.out_rate};
        default: rd_ok = 1'b0;
      endcase
    end else begin
      rd_ok = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write range checks; a bad value is refused and leaves the item untouched
  always_comb begin
    wr_ok = 1'b0;
    area = 32'h0;
    if (cat_tx) begin
      unique case (cmd.item)
        `SNIP_TX_CHANNEL_ENABLE,
        `SNIP_TX_FEC_GENERATE,
        `SNIP_TX_ENCAPSULATION: wr_ok = cmd.data <= {56'h0, `SNIP_BOOL_MAX};
        `SNIP_TX_FEC_COLUMN_COUNT: begin
          area = cmd.data[15:0] * s_q.fec_row;
          wr_ok = cmd.data[63:16] == 48'h0 && cmd.data[15:0] >= `SNIP_FEC_COL_MIN
            && cmd.data[15:0] <= `SNIP_FEC_COL_MAX && area <= `SNIP_FEC_AREA_MAX;
        end
        `SNIP_TX_FEC_ROW_COUNT: begin
          area = cmd.data[15:0] * s_q.fec_col;
          wr_ok = cmd.data[63:16] == 48'h0 && cmd.data[15:0] >= `SNIP_FEC_ROW_MIN
            && cmd.data[15:0] <= `SNIP_FEC_ROW_MAX && area <= `SNIP_FEC_AREA_MAX;
        end
        `SNIP_TX_DESTINATION_IP: wr_ok = cmd.data[63:32] == 32'h0;
        `SNIP_TX_DESTINATION_PORT: wr_ok = cmd.data[63:16] == 48'h0;
        `SNIP_TX_PACKETS_PER_DATAGRAM: wr_ok = cmd.data >= {56'h0, `SNIP_PPD_MIN}
          && cmd.data <= {56'h0, `SNIP_PPD_MAX};
        `SNIP_TX_HOP_LIMIT: wr_ok = cmd.data[63:8] == 56'h0;
        default: wr_ok = 1'b0;
      endcase
    end else if (cat_in) begin
      unique case (cmd.item)
        `SNIP_IN_PACKET_LENGTH_SELECT: wr_ok = cmd.data <= {56'h0, `SNIP_LEN_SEL_MAX};
        `SNIP_IN_SOURCE_SELECT: wr_ok = cmd.data <= {56'h0, `SNIP_SRC_SEL_MAX};
        default: wr_ok = 1'b0;
      endcase
    end else if (cat_out) begin
      wr_ok = cmd.item == `SNIP_OUT_PACKET_LENGTH_SELECT
        && cmd.data <= {56'h0, `SNIP_LEN_SEL_MAX};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.resolve = {7'h0, resolve_failed};
    s_d.link = {6'h0, link_state};
    s_d.in_rate = in_rate_bps;
    s_d.out_rate = out_rate_bps;
    // counters wrap silently at 64 bits, far beyond any uptime
    if (byte_received) begin
      s_d.byte_cnt = s_q.byte_cnt + 64'h1;
    end
    if (code_violation) begin
      s_d.viol_cnt = s_q.viol_cnt + 64'h1;
    end
    s_d.rsp.valid = cmd.valid;
    s_d.rsp.ok = cmd.valid && (wr ? wr_ok : rd_ok);
    s_d.rsp.data = rd_data;
    if (wr && wr_ok) begin
      if (cat_tx) begin
        unique case (cmd.item)
          `SNIP_TX_CHANNEL_ENABLE: s_d.tx_enable = cmd.data[7:0];
          `SNIP_TX_FEC_GENERATE: s_d.fec_gen = cmd.data[7:0];
          `SNIP_TX_FEC_COLUMN_COUNT: s_d.fec_col = cmd.data[15:0];
          `SNIP_TX_FEC_ROW_COUNT: s_d.fec_row = cmd.data[15:0];
          `SNIP_TX_DESTINATION_IP: s_d.dest_ip = cmd.data[31:0];
          `SNIP_TX_DESTINATION_PORT: s_d.dest_port = cmd.data[15:0];
          `SNIP_TX_PACKETS_PER_DATAGRAM: s_d.ppd = cmd.data[7:0];
          `SNIP_TX_ENCAPSULATION: s_d.encap = cmd.data[7:0];
          `SNIP_TX_HOP_LIMIT: s_d.hop = cmd.data[7:0];
          default: s_d.hop = s_q.hop;
        endcase
      end else if (cat_in) begin
        if (cmd.item == `SNIP_IN_PACKET_LENGTH_SELECT) begin
          s_d.in_len = cmd.data[7:0];
        end else begin
          s_d.src_sel = cmd.data[7:0];
        end
      end else begin
        s_d.out_len = cmd.data[7:0];
      end
      s_d.rsp.data = cmd.data; // write reply echoes the value
    end
    // datapath view, registered so outputs come straight from flops
    s_d.cfg.enable = s_d.tx_enable[0];
    s_d.cfg.fec_generate = s_d.fec_gen[0];
    s_d.cfg.tx_fec_column_count = s_d.fec_col[4:0];
    s_d.cfg.tx_fec_row_count = s_d.fec_row[4:0];
    s_d.cfg.destination_ip = s_d.dest_ip;
    s_d.cfg.destination_port = s_d.dest_port;
    s_d.cfg.packets_per_datagram = s_d.ppd[2:0];
    s_d.cfg.rtp = s_d.encap[0];
    s_d.cfg.hop_limit = s_d.hop;
    s_d.cfg.in_length_select = s_d.in_len[1:0];
    s_d.cfg.source_select = s_d.src_sel[1:0];
    s_d.cfg.out_length_select = s_d.out_len[1:0];
    // zero length means pass the incoming size through
    unique case (s_d.in_len[1:0])
      2'h0: s_d.tx_len = `SNIP_PKT_LEN_188;
      2'h1: s_d.tx_len = `SNIP_PKT_LEN_204;
      default: s_d.tx_len = 8'h00;
    endcase
    unique case (s_d.out_len[1:0])
      2'h0: s_d.out_bytes = `SNIP_PKT_LEN_188;
      2'h1: s_d.out_bytes = `SNIP_PKT_LEN_204;
      default: s_d.out_bytes = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.tx_enable <= `SNIP_RST_ENABLE;
      s_q.fec_gen <= `SNIP_RST_FEC_GEN;
      s_q.fec_col <= `SNIP_RST_FEC_COL;
      s_q.fec_row <= `SNIP_RST_FEC_ROW;
      s_q.dest_ip <= `SNIP_RST_DEST_IP;
      s_q.dest_port <= `SNIP_RST_DEST_PORT;
      s_q.ppd <= `SNIP_RST_PPD;
      s_q.encap <= `SNIP_RST_ENCAP;
      s_q.hop <= `SNIP_RST_HOP;
      s_q.in_len <= `SNIP_RST_LEN_SEL;
      s_q.src_sel <= `SNIP_RST_SRC_SEL;
      s_q.out_len <= `SNIP_RST_LEN_SEL;
      s_q.cfg.tx_fec_column_count <= 5'h01;
      s_q.cfg.tx_fec_row_count <= 5'h04;
      s_q.cfg.packets_per_datagram <= 3'h7;
      s_q.cfg.hop_limit <= `SNIP_RST_HOP;
      s_q.tx_len <= `SNIP_PKT_LEN_188;
      s_q.out_bytes <= `SNIP_PKT_LEN_188;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp = s_q.rsp;
  assign cfg = s_q.cfg;
  assign tx_packet_length = s_q.tx_len;
  assign out_packet_bytes = s_q.out_bytes;

endmodule

//--- snip_bank_chk.sv
// concurrent checks on the transmit settings bank ports
`timescale 1ns/10ps
module snip_bank_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // mode and command port
  input wire logic asi_to_ip_mode,
  input wire snip_pkg::snip_cmd_t cmd,
  input wire snip_pkg::snip_rsp_t rsp,
  // settings to the datapath
  input wire snip_pkg::snip_cfg_t cfg,
  input wire logic [7:0] tx_packet_length,
  input wire logic [7:0] out_packet_bytes
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic rd_tx;
  logic wr_tx;
  assign rd_tx = cmd.valid && !cmd.write && asi_to_ip_mode && cmd.category == 8'h82;
  assign wr_tx = cmd.valid && cmd.write && cmd.category == 8'h82;
  a_answer_next: assert property (cmd.valid |=> rsp.valid)
    else $error("command not answered next cycle");
  a_no_stray: assert property (rsp.valid |-> $past(cmd.valid))
    else $error("reply without a command");
  a_fec_area: assert property (
    {5'h00, cfg.tx_fec_column_count} * {5'h00, cfg.tx_fec_row_count} <= 10'h064)
    else $error("fec matrix above limit");
  a_fec_bounds: assert property (
    cfg.tx_fec_column_count inside {[5'h01:5'h14]} && cfg.tx_fec_row_count inside {[5'h04:5'h14]})
    else $error("fec dimension out of range");
  a_ppd_bounds: assert property (cfg.packets_per_datagram != 3'h0)
    else $error("packets per datagram zero");
  a_in_mode_gate: assert property (
    cmd.valid && !asi_to_ip_mode && cmd.category inside {8'h82, 8'h83} |=> !rsp.ok)
    else $error("transmit item reached in wrong mode");
  a_out_mode_gate: assert property (
    cmd.valid && asi_to_ip_mode && cmd.category == 8'h84 |=> !rsp.ok)
    else $error("output item reached in wrong mode");
  a_channel_one: assert property (
    rd_tx && cmd.item == 8'h0b |=> rsp.ok && rsp.data == 64'h1)
    else $error("channel index not one");
  a_source_asi: assert property (
    rd_tx && cmd.item == 8'h0c |=> rsp.ok && rsp.data == 64'h1)
    else $error("input type not one");
  a_ro_refused: assert property (
    wr_tx && cmd.item inside {8'h07, 8'h0b, 8'h0c} |=> !rsp.ok)
    else $error("read-only item accepted a write");
  a_cfg_hold: assert property (!$stable(cfg) |-> $past(cmd.valid && cmd.write))
    else $error("settings changed without a write");
  a_len_code: assert property (
    tx_packet_length inside {8'hbc, 8'hcc, 8'h00}
    && out_packet_bytes inside {8'hbc, 8'hcc, 8'h00})
    else $error("packet length code illegal");
endmodule
bind snip_bank snip_bank_chk chk_i (.clock(clock), .rst_n(rst_n),
  .asi_to_ip_mode(asi_to_ip_mode), .cmd(cmd), .rsp(rsp), .cfg(cfg),
  .tx_packet_length(tx_packet_length), .out_packet_bytes(out_packet_bytes));

//--- snip_host.sv
// host controller model issuing category and item commands
`timescale 1ns/10ps
module snip_host (
  // clock
  input wire logic clock,
  // command port
  output snip_pkg::snip_cmd_t cmd,
  input wire snip_pkg::snip_rsp_t rsp
);
  initial cmd = '0;
  // one command, one answer; idle fields carry inverted junk so stale values never pass
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] i,
                      input logic [63:0] d, output logic [1:0] ok, output logic [63:0] q);
    @(posedge clock);
    cmd <= '{valid: 1'b1, write: w, category: c, item: i, index: 16'h0001, data: d};
    @(posedge clock);
    cmd <= '{valid: 1'b0, write: ~w, category: ~c, item: ~i, index: 16'hfffe, data: ~d};
    @(posedge clock);
    ok = {rsp.valid, rsp.ok};
    q = rsp.data;
  endtask
endmodule

//--- tb.sv
// self-checking bench for the transmit settings bank
`timescale 1ns/10ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b1;
  logic resolve_failed = 1'b0;
  logic [1:0] link_state = 2'h0;
  logic byte_rx = 1'b0;
  logic code_err = 1'b0;
  logic [31:0] in_rate = 32'h0123_4567;
  snip_pkg::snip_cmd_t cmd;
  snip_pkg::snip_rsp_t rsp;
  snip_pkg::snip_cfg_t cfg;
  logic [7:0] tx_len;
  logic [7:0] out_len;
  logic [1:0] ok;
  logic [63:0] q;
  int num_errors = 0;
  int num_checks = 0;
  always #5 clock = ~clock;
  snip_bank uut (.clock(clock), .rst_n(rst_n), .asi_to_ip_mode(mode), .cmd(cmd), .rsp(rsp),
    .resolve_failed(resolve_failed), .link_state(link_state), .in_rate_bps(in_rate),
    .out_rate_bps(32'h89ab_cdef), .byte_received(byte_rx), .code_violation(code_err),
    .cfg(cfg), .tx_packet_length(tx_len), .out_packet_bytes(out_len));
  snip_host host (.clock(clock), .cmd(cmd), .rsp(rsp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // d is the write value, or the expected read value
  task automatic op(input logic w, input logic [7:0] c, input logic [7:0] i,
                    input logic [63:0] d, input logic e);
    host.xfer(w, c, i, d, ok, q);
    chk("reply", {62'h0, ok}, {62'h0, 1'b1, e});
    if (e) chk("data", q, d);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    op(0, 8'h82, 8'h01, 64'h0, 1'b1);
    op(0, 8'h82, 8'h04, 64'h1, 1'b1);
    op(0, 8'h82, 8'h05, 64'h4, 1'b1);
    op(0, 8'h82, 8'h0b, 64'h1, 1'b1);
    op(0, 8'h82, 8'h0c, 64'h1, 1'b1);
    op(0, 8'h83, 8'h02, 64'h1, 1'b1);
    op(0, 8'h83, 8'h07, 64'h0, 1'b1);
    op(0, 8'h84, 8'h01, 64'h0, 1'b0);
    chk("lengths", {48'h0, tx_len, out_len}, 64'hbcbc);
  endtask
  // the limit is checked against the stored other dimension
  task automatic t_fec_matrix;
    op(1, 8'h82, 8'h04, 64'h14, 1'b1);
    op(1, 8'h82, 8'h05, 64'h05, 1'b1);
    op(1, 8'h82, 8'h05, 64'h06, 1'b0);
    op(1, 8'h82, 8'h04, 64'h15, 1'b0);
    op(1, 8'h82, 8'h04, 64'h00, 1'b0);
    op(1, 8'h82, 8'h05, 64'h03, 1'b0);
    op(0, 8'h82, 8'h05, 64'h05, 1'b1);
    op(1, 8'h82, 8'h04, 64'h01, 1'b1);
    op(1, 8'h82, 8'h05, 64'h14, 1'b1);
    op(1, 8'h82, 8'h05, 64'h15, 1'b0);
    chk("fec", {54'h0, cfg.tx_fec_column_count, cfg.tx_fec_row_count}, 64'h34);
  endtask
  task automatic t_items;
    op(1, 8'h82, 8'h01, 64'h1, 1'b1);
    op(1, 8'h82, 8'h01, 64'h2, 1'b0);
    op(1, 8'h82, 8'h06, 64'hc0a8_0a01, 1'b1);
    op(1, 8'h82, 8'h06, 64'h1_0000_0000, 1'b0);
    op(0, 8'h82, 8'h06, 64'hc0a8_0a01, 1'b1);
    op(1, 8'h82, 8'h03, 64'h1, 1'b1);
    op(1, 8'h82, 8'h03, 64'h2, 1'b0);
    op(1, 8'h82, 8'h08, 64'hffff, 1'b1);
    op(0, 8'h82, 8'h08, 64'hffff, 1'b1);
    op(1, 8'h82, 8'h09, 64'h0, 1'b0);
    op(1, 8'h82, 8'h09, 64'h8, 1'b0);
    op(1, 8'h82, 8'h09, 64'h7, 1'b1);
    op(1, 8'h82, 8'h09, 64'h1, 1'b1);
    op(1, 8'h82, 8'h0a, 64'h1, 1'b1);
    op(1, 8'h82, 8'h0a, 64'h2, 1'b0);
    op(1, 8'h82, 8'h0d, 64'hff, 1'b1);
    op(1, 8'h82, 8'h0b, 64'h2, 1'b0);
    op(1, 8'h82, 8'h02, 64'h0, 1'b0);
    chk("cfg", {35'h0, cfg.fec_generate, cfg.destination_port, cfg.packets_per_datagram,
      cfg.rtp, cfg.hop_limit}, 64'h1fff_f3ff);
    chk("dest", {31'h0, cfg.enable, cfg.destination_ip}, 64'h1_c0a8_0a01);
  endtask
  task automatic t_lengths(input logic [7:0] c);
    logic [7:0] len [3] = '{8'hbc, 8'hcc, 8'h00};
    logic [7:0] seen;
    logic [5:0] sel;
    logic [5:0] exp_sel;
    for (int k = 0; k < 4; k++) begin
      op(1, c, 8'h01, 64'(k), k < 3);
      if (c == 8'h83) op(1, c, 8'h07, 64'(k), k < 3);
      @(posedge clock);
      seen = c == 8'h83 ? tx_len : out_len;
      sel = {cfg.in_length_select, cfg.source_select, cfg.out_length_select};
      exp_sel = c == 8'h83 ? {2'(k), 2'(k), 2'h0} : {4'h0, 2'(k)};
      if (k < 3) chk("length", {56'h0, seen}, {56'h0, len[k]});
      if (k < 3) chk("select", {58'h0, sel}, {58'h0, exp_sel});
    end
  endtask
  // counters see a pulse train of known length
  task automatic t_status;
    resolve_failed <= 1'b1;
    link_state <= 2'h3;
    byte_rx <= 1'b1;
    code_err <= 1'b1;
    repeat (3) @(posedge clock);
    code_err <= 1'b0;
    repeat (2) @(posedge clock);
    byte_rx <= 1'b0;
    op(0, 8'h82, 8'h07, 64'h1, 1'b1);
    op(0, 8'h83, 8'h03, 64'h3, 1'b1);
    op(0, 8'h83, 8'h05, 64'h5, 1'b1);
    op(0, 8'h83, 8'h06, 64'h3, 1'b1);
    op(0, 8'h83, 8'h04, 64'h0123_4567, 1'b1);
    resolve_failed <= 1'b0;
    link_state <= 2'h1;
    in_rate <= 32'h0765_4321;
    op(0, 8'h82, 8'h07, 64'h0, 1'b1);
    op(0, 8'h83, 8'h03, 64'h1, 1'b1);
    op(0, 8'h83, 8'h04, 64'h0765_4321, 1'b1);
  endtask
  // a second reset mid-run restores defaults and clears the counters
  task automatic t_rerun_reset;
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    chk("lengths", {48'h0, tx_len, out_len}, 64'hbcbc);
    op(0, 8'h83, 8'h05, 64'h0, 1'b1);
    op(0, 8'h83, 8'h06, 64'h0, 1'b1);
    op(0, 8'h82, 8'h05, 64'h4, 1'b1);
  endtask
  task automatic t_mode;
    mode <= 1'b0;
    op(0, 8'h82, 8'h0b, 64'h1, 1'b0);
    op(0, 8'h83, 8'h02, 64'h1, 1'b0);
    op(0, 8'h84, 8'h02, 64'h1, 1'b1);
    op(0, 8'h84, 8'h03, 64'h89ab_cdef, 1'b1);
    t_lengths(8'h84);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_reset_values();
    t_fec_matrix();
    t_items();
    t_lengths(8'h83);
    t_status();
    t_rerun_reset();
    t_mode();
    complete_run();
  end
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
endmodule
